// ### design/dlp_controller.sv
// controller end: per-constraint counters gate the mode-set, locked-dll and short-calibration command classes
// assumes user requests arrive on core_clk; one request at a time
`timescale 1ns/10ps
`default_nettype none
`include "dlp_defines.svh"
module dlp_controller #(
  parameter int WRITE_RECOVERY_PS = 15000
) (
  // clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // user request
  input  wire dlp_pkg::dlp_cmd_t   req_cmd,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire dlp_pkg::dlp_burst_t req_burst,
  input  wire logic [3:0]          req_write_latency,
  input  wire logic                req_powerdown,
  // link
  dlp_link_if.ctrl         link
);
  import dlp_pkg::*;

  // round a picosecond figure up to whole cycles, at least one
  function automatic logic [7:0] ps_to_nck(input int ps);
    int n;
    n = (ps + `DLP_CLK_PERIOD_PS - 1) / `DLP_CLK_PERIOD_PS;
    ps_to_nck = (n < 1) ? 8'h01 : 8'(n);
  endfunction

  localparam logic [7:0] WR_NCK   = ps_to_nck(WRITE_RECOVERY_PS);
  localparam logic [7:0] XPDLL_NCK = (ps_to_nck(`DLP_FROZEN_EXIT_PS) > 8'(`DLP_FROZEN_EXIT_MIN_NCK)) ?
                                      ps_to_nck(`DLP_FROZEN_EXIT_PS) : 8'(`DLP_FROZEN_EXIT_MIN_NCK);

  logic [7:0] mrs_cnt_q, lvl_cnt_q, pd_cnt_q, mpr_cnt_q, dll_cnt_q, zq_cnt_q;
  logic       lvl_active_q, cke_q;

  wire logic is_mrs   = (req_cmd == DLP_CMD_MRS) || (req_cmd == DLP_CMD_LEVEL) || (req_cmd == DLP_CMD_MPR);
  wire logic need_dll = (req_cmd == DLP_CMD_RD) || (req_cmd == DLP_CMD_RDA) || (req_cmd == DLP_CMD_ODT);
  wire logic is_wr    = (req_cmd == DLP_CMD_WR) || (req_cmd == DLP_CMD_WRA);

  // each gated class blocked until its counters run out; mode-set class also waits on mpr_cnt_q, which only RD loads (not RDA or ODT)
  always_comb begin
    req_ready = cke_q && !req_powerdown;
    if (is_mrs && (mrs_cnt_q != 8'h00 || mpr_cnt_q != 8'h00)) req_ready = 1'b0;
    if (need_dll && (!link.dll_locked || dll_cnt_q != 8'h00)) req_ready = 1'b0;
    if (req_cmd == DLP_CMD_SHORT_IMPEDANCE_CALIBRATION && zq_cnt_q != 8'h00) req_ready = 1'b0;
  end
  wire logic fire = req_valid && req_ready;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.cmd       <= DLP_CMD_NOP;
      link.cmd_valid <= 1'b0;
      link.burst     <= DLP_BURST_FULL;
      link.write_latency <= 4'(`DLP_WL_RESET_NCK);
      link.wr_cycles <= 5'h00;
    end else begin
      link.cmd_valid <= fire;
      link.cmd       <= fire ? req_cmd : DLP_CMD_NOP;
      if (fire) begin
        link.burst         <= req_burst;
        link.write_latency <= req_write_latency;
        link.wr_cycles     <= 5'(WR_NCK);
      end
    end
  end

  // counters decrement on edges only
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      mrs_cnt_q <= 8'h00;
      mpr_cnt_q <= 8'h00;
    end else begin
      mrs_cnt_q <= (fire && is_mrs) ? 8'(`DLP_MODE_SET_NCK - 1) :
                   (mrs_cnt_q != 8'h00 ? mrs_cnt_q - 8'h01 : 8'h00);
      mpr_cnt_q <= (fire && req_cmd == DLP_CMD_RD) ? 8'(`DLP_MPR_SPACING_NCK + `DLP_MPR_BURST_NCK) :
                   (mpr_cnt_q != 8'h00 ? mpr_cnt_q - 8'h01 : 8'h00);
    end
  end

  // drift-based gap between short calibrations is fixed at build time, not measured
  always_ff @(posedge core_clk) begin
    if (!resetn)
      zq_cnt_q <= 8'h00;
    else if (fire && req_cmd == DLP_CMD_SHORT_IMPEDANCE_CALIBRATION)
      zq_cnt_q <= 8'(`DLP_SHORT_IMPEDANCE_CALIBRATION_GAP_NCK - 1);
    else if (zq_cnt_q != 8'h00)
      zq_cnt_q <= zq_cnt_q - 8'h01;
  end

  // write leveling strobe timing
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      lvl_cnt_q    <= 8'h00;
      lvl_active_q <= 1'b0;
    end else if (fire && req_cmd == DLP_CMD_LEVEL) begin
      lvl_cnt_q    <= 8'h00;
      lvl_active_q <= 1'b1;
    end else if (fire && req_cmd == DLP_CMD_MRS) begin
      lvl_active_q <= 1'b0;
    end else if (lvl_active_q && lvl_cnt_q != 8'hFF) begin
      lvl_cnt_q <= lvl_cnt_q + 8'h01;
    end
  end
  assign link.strobe_en   = lvl_active_q && (lvl_cnt_q >= 8'(`DLP_LEVEL_STROBE_NCK));
  assign link.strobe_rise = lvl_active_q && (lvl_cnt_q == 8'(`DLP_LEVEL_FIRST_NCK));

  // power-down entry guard: write, refresh; clock may be slow, refresh kept by user
  always_ff @(posedge core_clk) begin
    if (!resetn)
      pd_cnt_q <= 8'h00;
    else if (fire && is_wr)
      pd_cnt_q <= 8'({4'h0, req_write_latency}) + 8'(`DLP_WRPD_EXTRA_NCK) + WR_NCK;
    else if (fire && req_cmd == DLP_CMD_REF)
      pd_cnt_q <= 8'(`DLP_REF_PD_NCK);
    else if (pd_cnt_q != 8'h00)
      pd_cnt_q <= pd_cnt_q - 8'h01;
  end

  // cke may drop while device still busy; device finishes internally
  always_ff @(posedge core_clk) begin
    if (!resetn)
      cke_q <= 1'b1;
    else if (req_powerdown && pd_cnt_q == 8'h00 && !fire)
      cke_q <= 1'b0;
    else if (!req_powerdown)
      cke_q <= 1'b1;
  end
  assign link.cke = cke_q;

  // after power-down exit, locked-dll commands wait the frozen exit delay
  always_ff @(posedge core_clk) begin
    if (!resetn)
      dll_cnt_q <= 8'h00;
    else if (!cke_q)
      dll_cnt_q <= XPDLL_NCK;
    else if (dll_cnt_q != 8'h00)
      dll_cnt_q <= dll_cnt_q - 8'h01;
  end
endmodule
`default_nettype wire

// ### design/dlp_defines.svh
// timing constants for the dram timing-rule pair (device end and controller end)
// assumes a single 10 MHz core clock; all counts are in clock cycles
`ifndef DLP_DEFINES_SVH
`define DLP_DEFINES_SVH
`define DLP_CLK_PERIOD_PS      100000
`define DLP_LEVEL_FIRST_NCK    40
`define DLP_LEVEL_STROBE_NCK   25
`define DLP_MODE_SET_NCK       4
`define DLP_WSTART_FULL_NCK    4
`define DLP_WSTART_FIXCHOP_NCK 2
`define DLP_WRPD_EXTRA_NCK     4
`define DLP_SHORT_IMPEDANCE_CALIBRATION_MAX_NCK       64
`define DLP_SHORT_IMPEDANCE_CALIBRATION_WORK_NCK      8
`define DLP_SHORT_IMPEDANCE_CALIBRATION_STEP_PERMIL   5
`define DLP_REF_BUSY_NCK       6
`define DLP_ACT_BUSY_NCK       3
`define DLP_FROZEN_EXIT_PS     24000
`define DLP_REF_PD_NCK         1
`define DLP_MPR_SPACING_NCK    4
`define DLP_MPR_BURST_NCK      4
`define DLP_FROZEN_EXIT_MIN_NCK 10
`define DLP_SHORT_IMPEDANCE_CALIBRATION_GAP_NCK       16
`define DLP_WL_RESET_NCK       5
`endif

// ### design/dlp_pkg.sv
// shared types for the dram timing-rule pair
// assumes nothing beyond the defines header
package dlp_pkg;
  typedef enum logic [3:0] {
    DLP_CMD_NOP   = 4'h0,
    DLP_CMD_MRS   = 4'h1,
    DLP_CMD_ACT   = 4'h2,
    DLP_CMD_PRE   = 4'h3,
    DLP_CMD_RD    = 4'h4,
    DLP_CMD_RDA   = 4'h5,
    DLP_CMD_WR    = 4'h6,
    DLP_CMD_WRA   = 4'h7,
    DLP_CMD_REF   = 4'h8,
    DLP_CMD_SHORT_IMPEDANCE_CALIBRATION  = 4'h9,
    DLP_CMD_ODT   = 4'hA,
    DLP_CMD_LEVEL = 4'hB,
    DLP_CMD_MPR   = 4'hC
  } dlp_cmd_t;
  typedef enum logic [1:0] {
    DLP_BURST_FULL     = 2'h0,
    DLP_BURST_CHOP_OTF = 2'h1,
    DLP_BURST_CHOP_FIX = 2'h2
  } dlp_burst_t;
endpackage

// ### design/dlp_link_if.sv
// command link between controller end and device end
// assumes both ends share core_clk
`timescale 1ns/10ps
`default_nettype none
interface dlp_link_if;
  import dlp_pkg::*;
  dlp_cmd_t   cmd;
  logic       cmd_valid;
  dlp_burst_t burst;
  logic [3:0] write_latency;
  logic [4:0] wr_cycles;
  logic       cke;
  logic       strobe_en;
  logic       strobe_rise;
  logic       dll_locked;
  modport ctrl (output cmd, cmd_valid, burst, write_latency, wr_cycles, cke, strobe_en, strobe_rise,
                input dll_locked);
  modport dev  (input cmd, cmd_valid, burst, write_latency, wr_cycles, cke, strobe_en, strobe_rise,
                output dll_locked);
endinterface
`default_nettype wire

// ### design/dlp_device.sv
// device end: write start timing, mode-register write recovery, power-down, short calibration
// assumes the controller end keeps its own spacing; link signals are on core_clk
`timescale 1ns/10ps
`default_nettype none
`include "dlp_defines.svh"
module dlp_device (
  // clock and reset
  input  wire logic     core_clk,
  input  wire logic     resetn,
  // link
  dlp_link_if.dev       link,
  // user side
  output logic          write_start,
  output logic          powered_down,
  output logic          calib_busy,
  output logic [7:0]    calib_step_permil,
  output logic [4:0]    wr_recovery_q
);
  import dlp_pkg::*;

  typedef enum logic [2:0] {
    DLP_PD_RUN  = 3'b001,
    DLP_PD_WAIT = 3'b010,
    DLP_PD_DOWN = 3'b100
  } dlp_pd_t;

  logic [31:0] wstart_pend_q;
  logic [7:0]  ref_busy_q;
  logic [7:0]  act_busy_q;
  logic [6:0]  calib_cnt_q;
  dlp_pd_t    pd_q;
  logic       dll_q;

  function automatic logic [7:0] wstart_delay(input logic [3:0] wl, input dlp_burst_t b);
    wstart_delay = {4'h0, wl} + ((b == DLP_BURST_CHOP_FIX) ? 8'(`DLP_WSTART_FIXCHOP_NCK)
                                                           : 8'(`DLP_WSTART_FULL_NCK));
  endfunction

  wire logic        wr_cmd     = link.cmd_valid && (link.cmd == DLP_CMD_WR || link.cmd == DLP_CMD_WRA);
  wire logic [31:0] wstart_bit = 32'h00000001 << (wstart_delay(link.write_latency, link.burst) - 8'h01);

  // one bit per pending write, shifted on edges not time, so back-to-back writes each keep their start
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wstart_pend_q <= 32'h00000000;
      write_start   <= 1'b0;
    end else begin
      write_start <= wstart_pend_q[0];
      if (wr_cmd)
        wstart_pend_q <= (wstart_pend_q >> 1) | wstart_bit;
      else
        wstart_pend_q <= wstart_pend_q >> 1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn)
      wr_recovery_q <= 5'h00;
    else if (link.cmd_valid && link.cmd == DLP_CMD_MRS)
      wr_recovery_q <= link.wr_cycles;
  end

  // internal operations keep running even after cke drops; separate counters so a
  // row command cannot cut short a refresh still in progress
  always_ff @(posedge core_clk) begin
    if (!resetn)
      ref_busy_q <= 8'h00;
    else if (link.cmd_valid && link.cmd == DLP_CMD_REF)
      ref_busy_q <= 8'(`DLP_REF_BUSY_NCK);
    else if (ref_busy_q != 8'h00)
      ref_busy_q <= ref_busy_q - 8'h01;
  end

  always_ff @(posedge core_clk) begin
    if (!resetn)
      act_busy_q <= 8'h00;
    else if (link.cmd_valid && (link.cmd inside {DLP_CMD_ACT, DLP_CMD_PRE, DLP_CMD_RDA, DLP_CMD_WRA}))
      act_busy_q <= 8'(`DLP_ACT_BUSY_NCK);
    else if (act_busy_q != 8'h00)
      act_busy_q <= act_busy_q - 8'h01;
  end
  wire logic busy = (ref_busy_q != 8'h00) || (act_busy_q != 8'h00);

  always_ff @(posedge core_clk) begin
    if (!resetn)
      pd_q <= DLP_PD_RUN;
    else begin
      case (pd_q)
        DLP_PD_RUN:  if (!link.cke) pd_q <= busy ? DLP_PD_WAIT : DLP_PD_DOWN;
        DLP_PD_WAIT: if (link.cke) pd_q <= DLP_PD_RUN;
                     else if (!busy) pd_q <= DLP_PD_DOWN;
        DLP_PD_DOWN: if (link.cke) pd_q <= DLP_PD_RUN;
        default:     pd_q <= DLP_PD_RUN;
      endcase
    end
  end
  assign powered_down = (pd_q == DLP_PD_DOWN);

  // dll counts as unlocked while powered down so the controller waits the frozen exit delay
  always_ff @(posedge core_clk) begin
    if (!resetn)
      dll_q <= 1'b1;
    else
      dll_q <= (pd_q == DLP_PD_RUN) && link.cke;
  end
  assign link.dll_locked = dll_q;

  // a fixed work time well under the 64-cycle bound
  always_ff @(posedge core_clk) begin
    if (!resetn)
      calib_cnt_q <= 7'h00;
    else if (link.cmd_valid && link.cmd == DLP_CMD_SHORT_IMPEDANCE_CALIBRATION)
      calib_cnt_q <= 7'(`DLP_SHORT_IMPEDANCE_CALIBRATION_WORK_NCK);
    else if (calib_cnt_q != 7'h00)
      calib_cnt_q <= calib_cnt_q - 7'h01;
  end
  assign calib_busy        = (calib_cnt_q != 7'h00);
  assign calib_step_permil = 8'(`DLP_SHORT_IMPEDANCE_CALIBRATION_STEP_PERMIL);
endmodule
`default_nettype wire

// ### tb/dlp_monitor.sv
// link checker: spacing and wake rules seen on the link
// assumes it sits beside the link interface, all on core_clk
`timescale 1ns/10ps
`default_nettype none
module dlp_monitor (
  // clock and reset
  input wire logic              core_clk,
  input wire logic              resetn,
  // link
  input wire dlp_pkg::dlp_cmd_t cmd,
  input wire logic              cmd_valid,
  input wire logic [3:0]        write_latency,
  input wire logic [4:0]        wr_cycles,
  input wire logic              cke,
  input wire logic              strobe_en,
  input wire logic              strobe_rise,
  input wire logic              dll_locked
);
  import dlp_pkg::*;
  logic [7:0] lvl_q;
  logic [7:0] wr_q;
  logic [7:0] xp_q;
  wire        is_set = cmd_valid && (cmd inside {DLP_CMD_MRS, DLP_CMD_LEVEL, DLP_CMD_MPR});
  wire        is_rd  = cmd_valid && (cmd inside {DLP_CMD_RD, DLP_CMD_RDA, DLP_CMD_ODT});
  // saturates so a long idle never wraps into a false pass
  always_ff @(posedge core_clk) begin
    if (!resetn) lvl_q <= 8'hFF;
    else if (cmd_valid && cmd == DLP_CMD_LEVEL) lvl_q <= 8'h00;
    else if (lvl_q != 8'hFF) lvl_q <= lvl_q + 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) wr_q <= 8'h00;
    else if (cmd_valid && cmd inside {DLP_CMD_WR, DLP_CMD_WRA}) wr_q <= 8'(write_latency) + 8'h04 + 8'(wr_cycles);
    else if (wr_q != 8'h00) wr_q <= wr_q - 8'h01;
  end
  always_ff @(posedge core_clk) begin
    if (!resetn) xp_q <= 8'h00;
    else if ($rose(cke)) xp_q <= 8'h0A;
    else if (xp_q != 8'h00) xp_q <= xp_q - 8'h01;
  end
  mode_set_gap_a: assert property (@(posedge core_clk) disable iff (!resetn)
    is_set |=> !is_set [*3]) else $error("mode sets too close");
  strobe_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strobe_en |-> lvl_q >= 8'h18) else $error("strobe driven early");
  first_rise_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strobe_rise |-> lvl_q >= 8'h27 && strobe_en) else $error("strobe rise early");
  rise_pulse_a: assert property (@(posedge core_clk) disable iff (!resetn)
    strobe_rise |=> !strobe_rise) else $error("strobe rise not a pulse");
  locked_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    is_rd |-> $past(dll_locked)) else $error("read without locked dll");
  wake_read_a: assert property (@(posedge core_clk) disable iff (!resetn)
    is_rd |-> xp_q <= 8'h01) else $error("read inside frozen exit");
  write_sleep_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(cke) |-> wr_q <= 8'h01) else $error("power-down too soon after write");
  awake_cmd_a: assert property (@(posedge core_clk) disable iff (!resetn)
    cmd_valid |-> $past(cke)) else $error("command while asleep");
endmodule
`default_nettype wire

// ### tb/ddr3_level_powerdown_timing_test.sv
// bench: controller and device joined by the link, scenarios by task
// assumes 10 MHz core_clk and synchronous active-low reset
`timescale 1ns/10ps
`default_nettype none
module ddr3_level_powerdown_timing_test;
  import dlp_pkg::*;
  logic       core_clk = 1'b0, resetn = 1'b0, req_valid = 1'b0, req_powerdown = 1'b0;
  dlp_cmd_t   req_cmd = DLP_CMD_NOP;
  dlp_burst_t req_burst = DLP_BURST_FULL;
  logic [3:0] req_write_latency = 4'h5;
  logic       req_ready, write_start, powered_down, calib_busy;
  logic [7:0] calib_step_permil;
  logic [4:0] wr_recovery_q;
  int         n_fail = 0, comparisons = 0, cyc = 0, t0, a, n, m;
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;
  dlp_link_if link ();
  // 250 ns recovery must round up to 3 cycles
  dlp_controller #(.WRITE_RECOVERY_PS(250000)) dlp_controller_i (.core_clk(core_clk), .resetn(resetn),
    .req_cmd(req_cmd), .req_valid(req_valid), .req_ready(req_ready), .req_burst(req_burst),
    .req_write_latency(req_write_latency), .req_powerdown(req_powerdown), .link(link));
  dlp_device dlp_device_i (.core_clk(core_clk), .resetn(resetn), .link(link), .write_start(write_start),
    .powered_down(powered_down), .calib_busy(calib_busy), .calib_step_permil(calib_step_permil),
    .wr_recovery_q(wr_recovery_q));
  dlp_monitor dlp_monitor_i (.core_clk(core_clk), .resetn(resetn), .cmd(link.cmd),
    .cmd_valid(link.cmd_valid), .write_latency(link.write_latency), .wr_cycles(link.wr_cycles),
    .cke(link.cke), .strobe_en(link.strobe_en), .strobe_rise(link.strobe_rise), .dll_locked(link.dll_locked));
  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one settled clock step; a wait that runs too long ends the run
  task automatic step(inout int k);
    @(posedge core_clk);
    #1;
    k++;
    if (k > 200) begin
      n_fail++;
      end_of_test();
    end
  endtask
  // holds the request until the edge that takes it
  task automatic issue(input dlp_cmd_t c, input dlp_burst_t b);
    int k;
    k = 0;
    @(posedge core_clk);
    req_cmd <= c;
    req_burst <= b;
    req_valid <= 1'b1;
    do begin
      @(negedge core_clk);
      k++;
      if (k > 200) begin
        n_fail++;
        end_of_test();
      end
    end while (req_ready !== 1'b1);
    @(posedge core_clk);
    req_valid <= 1'b0;
    t0 = cyc;
  endtask
  task automatic t_mode();
    issue(DLP_CMD_MRS, DLP_BURST_FULL);
    a = t0;
    issue(DLP_CMD_MRS, DLP_BURST_FULL);
    chk(32'(t0 - a), 32'h4);
    n = 0;
    repeat (3) step(n);
    chk(32'(wr_recovery_q), 32'h3);
  endtask
  task automatic t_write(input dlp_burst_t b, input int d);
    issue(DLP_CMD_WR, b);
    n = 0;
    do step(n); while (write_start !== 1'b1);
    chk(32'(n), 32'(d));
  endtask
  // back-to-back writes each start their own latency after their command
  task automatic t_pair();
    issue(DLP_CMD_WR, DLP_BURST_FULL);
    a = t0;
    issue(DLP_CMD_WR, DLP_BURST_FULL);
    n = 0;
    do step(n); while (write_start !== 1'b1);
    m = cyc;
    do step(n); while (write_start !== 1'b1);
    chk(32'(cyc - m), 32'(t0 - a));
  endtask
  task automatic t_sleep();
    issue(DLP_CMD_WR, DLP_BURST_FULL);
    a = t0;
    req_powerdown <= 1'b1;
    n = 0;
    do step(n); while (powered_down !== 1'b1);
    chk({30'h0, link.cke, link.dll_locked}, 32'h0);
    // controller takes cke low one edge after its write guard runs out, and the device shows power-down one edge after that
    chk(32'(cyc - a >= 14), 32'h1);
    @(posedge core_clk);
    req_powerdown <= 1'b0;
    a = cyc;
    issue(DLP_CMD_RD, DLP_BURST_FULL);
    chk(32'(t0 - a >= 10), 32'h1);
  endtask
  // a row command after refresh must not cut the 6-cycle refresh short
  task automatic t_refresh();
    issue(DLP_CMD_REF, DLP_BURST_FULL);
    issue(DLP_CMD_ACT, DLP_BURST_FULL);
    req_powerdown <= 1'b1;
    n = 0;
    do step(n); while (link.cke !== 1'b0);
    chk(32'(powered_down), 32'h0);
    do step(n); while (powered_down !== 1'b1);
    chk(32'(n), 32'h6);
    @(posedge core_clk);
    req_powerdown <= 1'b0;
  endtask
  task automatic t_level();
    issue(DLP_CMD_LEVEL, DLP_BURST_FULL);
    n = 0;
    do step(n); while (link.strobe_en !== 1'b1);
    chk(32'(n), 32'd25);
    do step(n); while (link.strobe_rise !== 1'b1);
    chk(32'(n), 32'd40);
  endtask
  task automatic t_calib();
    issue(DLP_CMD_SHORT_IMPEDANCE_CALIBRATION, DLP_BURST_FULL);
    a = t0;
    n = 0;
    do step(n); while (calib_busy !== 1'b1);
    m = n;
    do step(n); while (calib_busy === 1'b1);
    chk(32'(n - m <= 64), 32'h1);
    chk(32'(calib_step_permil), 32'h5);
    issue(DLP_CMD_SHORT_IMPEDANCE_CALIBRATION, DLP_BURST_FULL);
    chk(32'(t0 - a), 32'h10);
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    t_mode();
    t_write(DLP_BURST_FULL, 10);
    t_write(DLP_BURST_CHOP_OTF, 10);
    t_write(DLP_BURST_CHOP_FIX, 8);
    t_pair();
    t_sleep();
    t_refresh();
    t_level();
    t_calib();
    end_of_test();
  end
endmodule
`default_nettype wire
